// file: shared/nvdac_map.vh
// nvdac_map.vh: register offsets, field positions, reset values and timing
// counts for the non-volatile data access controller.
// assumes it is included by bare name from the design file.
`ifndef NVDAC_MAP_VH
`define NVDAC_MAP_VH

// special function register space, byte addresses within a bank
`define NVDAC_BANK0 1'b0
`define NVDAC_BANK1 1'b1
`define NVDAC_OFS_INDEX 8'h1A
`define NVDAC_OFS_VALUE 8'h1B
`define NVDAC_OFS_CONTROL 8'h40
`define NVDAC_OFS_IRQ 8'h1C

// control register fields
`define NVDAC_BIT_RD_START 0
`define NVDAC_BIT_RD_PERMIT 1
`define NVDAC_BIT_WR_START 2
`define NVDAC_BIT_WR_PERMIT 3

// interrupt register fields
`define NVDAC_BIT_DONE_EN 0
`define NVDAC_BIT_DONE_FLAG 1
`define NVDAC_BIT_MF_EN 2
`define NVDAC_BIT_MF_FLAG 3
`define NVDAC_BIT_GLB_EN 4

// reset values
`define NVDAC_RST_BYTE 8'h00
`define NVDAC_RST_INDEX 5'h00

// memory geometry
`define NVDAC_DEPTH 32
`define NVDAC_AW 5

// read cycle length in system cycles
`define NVDAC_READ_CYC 4'h4
// write timer: slow oscillator ticks per write cycle
`define NVDAC_WR_TICKS 8'h10

`endif

// file: rtl/nvdac_ctrl.v
// nvdac_ctrl.v: byte-wide non-volatile data store with its index, value,
// control and interrupt registers, behind the special function register port.
// assumes a cpu-side register port with a bank bit, one-cycle write and read
// strobes, and a free-running slow write-timer clock arriving as a pin.
//
// Behaviour
// R1 - 32 byte store, one byte per access
// R2 - index holds five bits, upper read zero
// R3 - write permit cleared at power-on
// R4 - write start needs write permit high
// R5 - read start needs read permit high
// R6 - write start self-clears when write ends
// R7 - read start self-clears, value then valid
// R8 - value register held until next operation
// R9 - write timed by asynchronous internal timer
// R10 - write end sets done and multi-function flags
// R11 - vector request needs all enables, stack free
// R12 - service clears only multi-function flag
// R13 - software never sets both starts together
// R14 - software sets write start right after permit
// R15 - software masks global interrupts around write start
// R16 - software: permit, index, start, then poll; the bench writes index and value before permit
// R17 - control reached indirectly in bank one
// R18 - index and value directly in bank zero
// R19 - software waits for completion before sleeping
// R20 - busy cycle ignores starts, keeps index, value
`timescale 1ns/10ps
`default_nettype none
`include "nvdac_map.vh"

module nvdac_ctrl (
    input wire clk_sys_i,
    input wire rst_i,
    input wire reg_bank_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    input wire wr_timer_clk_i,
    input wire stack_full_i,
    input wire irq_ack_i,
    output reg [7:0] reg_rdata_o,
    output reg irq_req_o,
    output reg busy_o
);

    // cycle states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_READ = 2'b01;
    localparam [1:0] ST_WRITE = 2'b10;

    // address decode shared by the write and read paths
    function hit;
        input bank;
        input [7:0] addr;
        input want_bank;
        input [7:0] want_addr;
        begin
            hit = (bank == want_bank) && (addr == want_addr);
        end
    endfunction

    reg [7:0] mem_q [0:`NVDAC_DEPTH-1]; // the store itself, see R1
    reg [`NVDAC_AW-1:0] index_q; // byte index
    reg [7:0] value_q; // byte value
    reg wr_permit_q; // write permit bit
    reg wr_start_q; // write start bit
    reg rd_permit_q; // read permit bit
    reg rd_start_q; // read start bit
    reg done_en_q; // write done interrupt enable
    reg done_flag_q; // write done request flag
    reg mf_en_q; // multi-function enable
    reg mf_flag_q; // multi-function request flag
    reg glb_en_q; // global interrupt enable
    reg [1:0] state_q; // cycle state
    reg [3:0] rd_cnt_q; // read cycle counter
    reg [`NVDAC_AW-1:0] cyc_index_q; // index latched for the cycle
    reg [7:0] cyc_value_q; // value latched for the write
    reg [7:0] tick_cnt_q; // timer ticks seen during a write
    reg [2:0] tmr_sync_q; // timer clock synchroniser
    reg tmr_prev_q; // agreed timer level
    reg [7:0] rdata_d; // read mux

    wire wr_idx = reg_wr_i && hit(reg_bank_i, reg_addr_i, `NVDAC_BANK0,
        `NVDAC_OFS_INDEX); // see R18
    wire wr_val = reg_wr_i && hit(reg_bank_i, reg_addr_i, `NVDAC_BANK0,
        `NVDAC_OFS_VALUE); // see R18
    wire wr_ctl = reg_wr_i && hit(reg_bank_i, reg_addr_i, `NVDAC_BANK1,
        `NVDAC_OFS_CONTROL); // see R17
    wire wr_irq = reg_wr_i && hit(reg_bank_i, reg_addr_i, `NVDAC_BANK0,
        `NVDAC_OFS_IRQ);
    wire idle = (state_q == ST_IDLE);
    // starts are honoured only with the permit already high, see R4 R5
    wire go_wr = wr_ctl && idle && wr_permit_q &&
        reg_wdata_i[`NVDAC_BIT_WR_START] && !wr_start_q;
    wire go_rd = wr_ctl && idle && rd_permit_q &&
        reg_wdata_i[`NVDAC_BIT_RD_START] && !rd_start_q && !go_wr;
    // timer edge counts once the second and third stages agree
    wire tmr_agree = (tmr_sync_q[1] == tmr_sync_q[2]);
    wire tmr_rise = tmr_agree && tmr_sync_q[2] && !tmr_prev_q;
    wire wr_end = (state_q == ST_WRITE) && tmr_rise &&
        (tick_cnt_q == `NVDAC_WR_TICKS - 8'h01); // see R9
    wire rd_end = (state_q == ST_READ) && (rd_cnt_q == 4'h1);

    // timer synchroniser; the first stage feeds only the second
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tmr_sync_q <= 3'h0;
            tmr_prev_q <= 1'b0;
        end else begin
            tmr_sync_q <= {tmr_sync_q[1:0], wr_timer_clk_i};
            if (tmr_agree) begin
                tmr_prev_q <= tmr_sync_q[2];
            end
        end
    end

    // store array: written only at the end of a timed write, see R1 R9
    always @(posedge clk_sys_i) begin
        if (wr_end) begin
            mem_q[cyc_index_q] <= cyc_value_q;
        end
    end

    // cycle sequencer
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            rd_cnt_q <= 4'h0;
            tick_cnt_q <= 8'h00;
            cyc_index_q <= `NVDAC_RST_INDEX;
            cyc_value_q <= `NVDAC_RST_BYTE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // latch what the cycle uses, see R20
                    cyc_index_q <= index_q;
                    cyc_value_q <= value_q;
                    tick_cnt_q <= 8'h00;
                    rd_cnt_q <= `NVDAC_READ_CYC;
                    if (go_wr) begin
                        state_q <= ST_WRITE;
                    end else if (go_rd) begin
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    rd_cnt_q <= rd_cnt_q - 4'h1;
                    if (rd_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    // timer ticks pace the write, see R9
                    if (tmr_rise) begin
                        tick_cnt_q <= tick_cnt_q + 8'h01;
                    end
                    if (wr_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // index, value and control registers
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            index_q <= `NVDAC_RST_INDEX;
            value_q <= `NVDAC_RST_BYTE;
            wr_permit_q <= 1'b0; // see R3
            wr_start_q <= 1'b0;
            rd_permit_q <= 1'b0;
            rd_start_q <= 1'b0;
        end else begin
            // index is five bits wide, see R2
            if (wr_idx) begin
                index_q <= reg_wdata_i[`NVDAC_AW-1:0];
            end
            // fetched byte lands at read end, else a value write loads it, else held, see R7 R8
            if (rd_end) begin
                value_q <= mem_q[cyc_index_q];
            end else if (wr_val) begin
                value_q <= reg_wdata_i;
            end
            if (wr_ctl) begin
                // permits follow software; clearing blocks, see R4 R5
                wr_permit_q <= reg_wdata_i[`NVDAC_BIT_WR_PERMIT];
                rd_permit_q <= reg_wdata_i[`NVDAC_BIT_RD_PERMIT];
            end
            // start bits set only on accepted start, see R4 R5 R20
            if (go_wr) begin
                wr_start_q <= 1'b1;
            end else if (wr_end) begin
                wr_start_q <= 1'b0; // see R6
            end
            if (go_rd) begin
                rd_start_q <= 1'b1;
            end else if (rd_end) begin
                rd_start_q <= 1'b0; // see R7
            end
        end
    end

    // interrupt enables and request flags
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            done_en_q <= 1'b0;
            done_flag_q <= 1'b0;
            mf_en_q <= 1'b0;
            mf_flag_q <= 1'b0;
            glb_en_q <= 1'b0;
        end else begin
            if (wr_irq) begin
                done_en_q <= reg_wdata_i[`NVDAC_BIT_DONE_EN];
                mf_en_q <= reg_wdata_i[`NVDAC_BIT_MF_EN];
                glb_en_q <= reg_wdata_i[`NVDAC_BIT_GLB_EN];
            end
            // set wins over a software clear, see R10
            if (wr_end) begin
                done_flag_q <= 1'b1;
            end else if (wr_irq) begin
                done_flag_q <= reg_wdata_i[`NVDAC_BIT_DONE_FLAG];
            end
            // service clears only the shared flag, see R10 R12
            if (wr_end) begin
                mf_flag_q <= 1'b1;
            end else if (irq_ack_i) begin
                mf_flag_q <= 1'b0;
            end else if (wr_irq) begin
                mf_flag_q <= reg_wdata_i[`NVDAC_BIT_MF_FLAG];
            end
        end
    end

    // vector request gated by all enables and the stack, see R11
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_req_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            irq_req_o <= glb_en_q && mf_en_q && done_en_q && done_flag_q &&
                mf_flag_q && !stack_full_i && !irq_ack_i;
            busy_o <= !idle && !wr_end && !rd_end;
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        rdata_d = 8'h00;
        if (hit(reg_bank_i, reg_addr_i, `NVDAC_BANK0, `NVDAC_OFS_INDEX)) begin
            rdata_d = {3'h0, index_q}; // see R2
        end else if (hit(reg_bank_i, reg_addr_i, `NVDAC_BANK0,
            `NVDAC_OFS_VALUE)) begin
            rdata_d = value_q;
        end else if (hit(reg_bank_i, reg_addr_i, `NVDAC_BANK1,
            `NVDAC_OFS_CONTROL)) begin
            rdata_d = {4'h0, wr_permit_q, wr_start_q, rd_permit_q,
                rd_start_q};
        end else if (hit(reg_bank_i, reg_addr_i, `NVDAC_BANK0,
            `NVDAC_OFS_IRQ)) begin
            rdata_d = {3'h0, glb_en_q, mf_flag_q, mf_en_q, done_flag_q,
                done_en_q};
        end
    end

    // registered read data, one cycle after the read strobe
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end
    end

endmodule
`default_nettype wire

// file: dv/nvdac_ctrl_assertions.sv
// nvdac_ctrl_assertions.sv: port-level checker for the nvdac controller.
// assumes the register map header and a single clk_sys_i domain.
`timescale 1ns/10ps
`default_nettype none
`include "nvdac_map.vh"
module nvdac_ctrl_chk (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic reg_bank_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic stack_full_i,
    input wire logic irq_ack_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_req_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // a control write in bank one, the only way to start a cycle
    wire ctl_wr = reg_wr_i && reg_bank_i &&
        reg_addr_i == `NVDAC_OFS_CONTROL;
    wire ctl_rd = reg_rd_i && reg_bank_i &&
        reg_addr_i == `NVDAC_OFS_CONTROL;
    wire idx_rd = reg_rd_i && !reg_bank_i && reg_addr_i == `NVDAC_OFS_INDEX;
    a_rdata_held: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_index_upper: assert property (idx_rd |=> reg_rdata_o[7:5] == 3'h0)
        else $error("index upper bits not zero");
    a_ctrl_upper: assert property (ctl_rd |=> reg_rdata_o[7:4] == 4'h0)
        else $error("control upper bits not zero");
    a_busy_cause: assert property ($rose(busy_o) |->
        $past(ctl_wr, 1) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
        else $error("cycle started without control write");
    a_busy_ends: assert property ($rose(busy_o) |-> ##[1:400] !busy_o)
        else $error("cycle never finished");
    a_busy_min: assert property ($rose(busy_o) |=> busy_o [*2])
        else $error("cycle too short");
    a_irq_stack: assert property (stack_full_i |=> !irq_req_o)
        else $error("vector request with stack full");
    a_irq_ack: assert property (irq_ack_i |=> !irq_req_o)
        else $error("vector request during service");
    a_reset_quiet: assert property ($fell(rst_i) |-> !busy_o && !irq_req_o)
        else $error("activity right after reset");
    // main scenarios reached
    c_cycle: cover property ($rose(busy_o));
    c_irq: cover property ($rose(irq_req_o));
    c_ack: cover property (irq_ack_i && irq_req_o);
endmodule
bind nvdac_ctrl nvdac_ctrl_chk u_nvdac_ctrl_chk (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .reg_bank_i(reg_bank_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .stack_full_i(stack_full_i),
    .irq_ack_i(irq_ack_i), .reg_rdata_o(reg_rdata_o),
    .irq_req_o(irq_req_o), .busy_o(busy_o));
`default_nettype wire

// file: dv/nvdac_ctrl_tb.sv
// nvdac_ctrl_tb.sv: self-checking bench for the nvdac controller.
// assumes the register map header; drives inputs 1 ns after each edge.
`timescale 1ns/10ps
`default_nettype none
`include "nvdac_map.vh"
module nvdac_ctrl_tb;
    logic clk_sys_i = 0, rst_i = 1, reg_bank_i = 0, reg_wr_i = 0;
    logic reg_rd_i = 0, wr_timer_clk_i = 0, stack_full_i = 0, irq_ack_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rv;
    wire [7:0] reg_rdata_o;
    wire irq_req_o, busy_o;
    int num_errors = 0, comparisons = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    // slow write timer, unrelated to the system clock
    always #37 wr_timer_clk_i = ~wr_timer_clk_i;
    nvdac_ctrl u_nvdac_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_bank_i(reg_bank_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .wr_timer_clk_i(wr_timer_clk_i), .stack_full_i(stack_full_i),
        .irq_ack_i(irq_ack_i), .reg_rdata_o(reg_rdata_o),
        .irq_req_o(irq_req_o), .busy_o(busy_o));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one register write, then an idle cycle
    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
        reg_bank_i = b; reg_addr_i = a; reg_wdata_i = d; reg_wr_i = 1;
        @(posedge clk_sys_i); #1 reg_wr_i = 0;
        @(posedge clk_sys_i); #1;
    endtask
    // one register read into rv
    task automatic rd(input logic b, input logic [7:0] a);
        reg_bank_i = b; reg_addr_i = a; reg_rd_i = 1;
        @(posedge clk_sys_i); #1 reg_rd_i = 0; rv = reg_rdata_o;
        @(posedge clk_sys_i); #1;
    endtask
    // poll control until the masked start bit clears
    task automatic poll(input logic [7:0] m);
        int i;
        i = 0; rv = m;
        while ((rv & m) !== 8'h00 && i < 300) begin
            rd(1, `NVDAC_OFS_CONTROL); i++;
        end
        chk(rv & m, 8'h00);
    endtask
    task automatic wbyte(input logic [7:0] ix, input logic [7:0] d);
        wr(0, `NVDAC_OFS_INDEX, ix); wr(0, `NVDAC_OFS_VALUE, d);
        // permit, then start on the very next access; never both starts
        wr(1, `NVDAC_OFS_CONTROL, 8'h08);
        wr(1, `NVDAC_OFS_CONTROL, 8'h0C);
        rd(1, `NVDAC_OFS_CONTROL); chk(rv, 8'h0C);
        chk({7'h00, busy_o}, 8'h01);
        wr(0, `NVDAC_OFS_VALUE, ~d); // late value must not reach the store
        // a permitted read start while the write runs must be ignored
        wr(1, `NVDAC_OFS_CONTROL, 8'h0A);
        wr(1, `NVDAC_OFS_CONTROL, 8'h0B);
        rd(1, `NVDAC_OFS_CONTROL); chk(rv, 8'h0E);
        poll(8'h04);
        chk({7'h00, busy_o}, 8'h00);
        rd(0, `NVDAC_OFS_IRQ); chk(rv & 8'h0A, 8'h0A);
        wr(1, `NVDAC_OFS_CONTROL, 8'h00);
    endtask
    task automatic rbyte(input logic [7:0] ix, input logic [7:0] d);
        wr(1, `NVDAC_OFS_CONTROL, 8'h02); wr(0, `NVDAC_OFS_INDEX, ix);
        wr(1, `NVDAC_OFS_CONTROL, 8'h03); poll(8'h01);
        rd(0, `NVDAC_OFS_VALUE); chk(rv, d);
        rd(0, `NVDAC_OFS_INDEX); rd(0, `NVDAC_OFS_VALUE); chk(rv, d);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        #1 rst_i = 0;
        rd(0, `NVDAC_OFS_INDEX); chk(rv, 8'h00);
        rd(1, `NVDAC_OFS_CONTROL); chk(rv, 8'h00);
        rd(0, 8'h00); chk(rv, 8'h00);
        wr(0, `NVDAC_OFS_INDEX, 8'hFF);
        rd(0, `NVDAC_OFS_INDEX); chk(rv, 8'h1F);
        wr(1, `NVDAC_OFS_CONTROL, 8'h01);
        rd(1, `NVDAC_OFS_CONTROL); chk(rv, 8'h00);
        wr(1, `NVDAC_OFS_CONTROL, 8'h0C);
        rd(1, `NVDAC_OFS_CONTROL); chk(rv, 8'h08);
        wr(1, `NVDAC_OFS_CONTROL, 8'h00);
        // both ends of the index range, then read back with a latched value
        wbyte(8'h00, 8'hA5); wbyte(8'h1F, 8'h3C);
        rbyte(8'h00, 8'hA5); rbyte(8'h1F, 8'h3C);
        // enable all interrupt paths, then block, service and inspect
        // global enable held off while the write starts, then turned on
        wr(0, `NVDAC_OFS_IRQ, 8'h05); wbyte(8'h05, 8'h5A);
        chk({7'h00, irq_req_o}, 8'h00);
        wr(0, `NVDAC_OFS_IRQ, 8'h1F);
        chk({7'h00, irq_req_o}, 8'h01);
        stack_full_i = 1; repeat (2) @(posedge clk_sys_i); #1;
        chk({7'h00, irq_req_o}, 8'h00);
        stack_full_i = 0; irq_ack_i = 1; @(posedge clk_sys_i); #1;
        irq_ack_i = 0; @(posedge clk_sys_i); #1;
        chk({7'h00, irq_req_o}, 8'h00);
        rd(0, `NVDAC_OFS_IRQ); chk(rv, 8'h17);
        wr(0, `NVDAC_OFS_IRQ, 8'h00); rbyte(8'h05, 8'h5A);
        stop_test;
    end
    // hang guard, far beyond the expected run
    initial begin
        #300000;
        num_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
